// file: src/iosmm_io_map.sv
// Purpose: I/O register map, program counter vectors and stack pointers.
// Assumes: CPU strobes come from logic on REF_CLK_IN and need no synchroniser.
// Notes: Register reads answer one cycle after the strobe on IO_RDATA_OUT.
module iosmm_io_map
  import iosmm_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  input wire logic CLK_EN_IN,
  input wire logic [7:0] IO_ADDR_IN,
  input wire logic [7:0] IO_X_IN,
  input wire logic [7:0] IO_ACC_IN,
  input wire logic IO_RD_IN,
  input wire logic IO_WR_IN,
  input wire logic IO_WRX_IN,
  output logic [7:0] IO_RDATA_OUT,
  input wire logic PC_STEP_IN,
  input wire logic PC_LOAD_IN,
  input wire logic [13:0] PC_LOAD_VAL_IN,
  input wire logic IRQ_TAKE_IN,
  input wire logic [2:0] IRQ_SRC_IN,
  output logic [13:0] PC_OUT,
  output logic PC_RANGE_ERR_OUT,
  input wire logic DS_PUSH_IN,
  input wire logic DS_POP_IN,
  input wire logic DS_LOAD_IN,
  input wire logic CS_PUSH_IN,
  input wire logic CS_POP_IN,
  input wire logic MEM_WR_IN,
  input wire logic MEM_RD_IN,
  input wire logic [7:0] MEM_ADDR_IN,
  input wire logic [7:0] MEM_WDATA_IN,
  output logic [7:0] MEM_RDATA_OUT,
  output logic [7:0] CALL_SP_OUT,
  output logic [7:0] DATA_SP_OUT,
  output logic [2:0] FIFO_HIT_OUT,
  input wire logic [7:0] EP1_MODE_SET_IN,
  input wire logic [7:0] EP2_MODE_SET_IN,
  input wire logic POR_EVENT_IN,
  input wire logic USB_RST_EVENT_IN,
  input wire logic WDR_EVENT_IN,
  output logic [31:0] PORT_DATA_OUT,
  output logic [31:0] PORT_IRQ_EN_OUT,
  output logic [7:0] DRIVE_CFG_OUT,
  output logic [7:0] USB_ADDR_OUT,
  output logic [7:0] TRAFFIC_CTRL_OUT,
  output logic [7:0] GLOBAL_IRQ_EN_OUT,
  output logic [7:0] EP_IRQ_EN_OUT,
  output logic [7:0] SINK_DATA_OUT,
  output logic [7:0] SINK_IRQ_EN_OUT,
  output logic [7:0] SINK_POL_OUT,
  output logic [31:0] SINK_CUR_OUT,
  output logic WDR_REQ_OUT
);
  typedef struct packed {
    logic [13:0] pc;
    logic pc_err;
    logic [7:0] csp;
    logic [7:0] dsp;
    logic [3:0][7:0] pdata;
    logic [3:0][7:0] pien;
    logic [7:0] dcfg;
    logic [7:0] uaddr;
    logic [7:0] ep0_cnt;
    logic [7:0] ep0_mode;
    logic [7:0] ep1_cnt;
    logic [7:0] ep1_mode;
    logic [7:0] ep2_cnt;
    logic [7:0] ep2_mode;
    logic [7:0] uctl;
    logic [7:0] gien;
    logic [7:0] eien;
    logic [11:0] tmr;
    logic [6:0] pre;
    logic [3:0] thi;
    logic [1:0] wdt;
    logic watchdog_reset;
    logic [7:0] sdata;
    logic [7:0] sien;
    logic [7:0] spol;
    logic [7:0][3:0] scur;
    logic [7:0] cstat;
    logic [7:0] rdata;
    logic [2:0] fifo;
  } iosmm_state_t;

  iosmm_state_t st_reg;
  iosmm_state_t st_next;
  logic [7:0] wr_addr;
  logic wr_any;
  logic [7:0] ram_addr;
  logic ram_we;
  logic ram_re;
  logic [7:0] ram_wdata;

  // Vector lookup; reserved slots can never be produced by a source code.
  function automatic logic [13:0] vec_of(input logic [2:0] src);
    logic [13:0] v;
    v = VEC_RESET;
    unique case (iosmm_irq_src_t'(src))
      SRC_BUS_RESET: v = VEC_BUS_RESET;
      SRC_TMR_128US: v = VEC_TMR_128US;
      SRC_TMR_1MS: v = VEC_TMR_1MS;
      SRC_EP0: v = VEC_EP0;
      SRC_EP1: v = VEC_EP1;
      SRC_EP2: v = VEC_EP2;
      SRC_SINK: v = VEC_SINK;
      SRC_GPIO: v = VEC_GPIO;
    endcase
    return v;
  endfunction

  // Indexed writes add X to the constant; a zero constant leaves X alone.
  // The sum wraps at eight bits on purpose, so it never leaves I/O space.
  assign wr_addr = IO_WRX_IN ? 8'(IO_ADDR_IN + IO_X_IN) : IO_ADDR_IN;
  assign wr_any = IO_WR_IN | IO_WRX_IN;

  // Stack and direct RAM traffic share one port, stacks first.
  always_comb begin
    ram_addr = MEM_ADDR_IN;
    ram_we = 1'b0;
    ram_re = 1'b0;
    ram_wdata = MEM_WDATA_IN;
    if (DS_PUSH_IN) begin
      ram_addr = st_reg.dsp - 8'h01;
      ram_we = 1'b1;
    end else if (DS_POP_IN) begin
      ram_addr = st_reg.dsp;
      ram_re = 1'b1;
    end else if (CS_PUSH_IN) begin
      ram_addr = st_reg.csp;
      ram_we = 1'b1;
    end else if (CS_POP_IN) begin
      ram_addr = st_reg.csp - 8'h01;
      ram_re = 1'b1;
    end else begin
      ram_we = MEM_WR_IN;
      ram_re = MEM_RD_IN;
    end
  end

  // Next-state logic for every register of the block.
  always_comb begin
    st_next = st_reg;
    st_next.watchdog_reset = 1'b0;
    // Program counter: interrupts win over jumps, jumps over stepping.
    // Nothing is stacked here; the CPU pushes through CS_PUSH_IN on interrupt
    // entry, and reset entry simply skips that step.
    if (IRQ_TAKE_IN) begin
      st_next.pc = vec_of(IRQ_SRC_IN);
    end else if (PC_LOAD_IN) begin
      st_next.pc = PC_LOAD_VAL_IN;
    end else if (PC_STEP_IN) begin
      st_next.pc = st_reg.pc + 14'h0001;
    end
    // Flags a program counter beyond the end of the programmed store. It is
    // taken from the next value so that it always agrees with PC_OUT.
    st_next.pc_err = (st_next.pc > PROG_STORE_END);
    // Stack pointers: call stack grows up, data stack grows down.
    // Both wrap at eight bits: a data push from zero lands at the top of RAM, in
    // the endpoint 0 FIFO, so firmware must load the data pointer first.
    if (DS_PUSH_IN) begin
      st_next.dsp = st_reg.dsp - 8'h01;
    end else if (DS_POP_IN) begin
      st_next.dsp = st_reg.dsp + 8'h01;
    end else if (DS_LOAD_IN) begin
      st_next.dsp = IO_ACC_IN;
    end else if (CS_PUSH_IN) begin
      st_next.csp = st_reg.csp + 8'h01;
    end else if (CS_POP_IN) begin
      st_next.csp = st_reg.csp - 8'h01;
    end
    // Record which endpoint FIFO the RAM access landed in.
    if (ram_we || ram_re) begin
      st_next.fifo[0] = (ram_addr >= EP0_FIFO_BASE);
      st_next.fifo[1] = (ram_addr >= EP1_FIFO_BASE) && (ram_addr < EP0_FIFO_BASE);
      st_next.fifo[2] = (ram_addr >= EP2_FIFO_BASE) && (ram_addr < EP1_FIFO_BASE);
    end
    // Free-running timer at one tick per microsecond.
    // The prescaler assumes the package clock period; a different core clock
    // needs new constants, or the timer runs fast or slow.
    if (st_reg.pre == TICK_LAST) begin
      st_next.pre = 7'h00;
      st_next.tmr = st_reg.tmr + 12'h001;
    end else begin
      st_next.pre = st_reg.pre + 7'h01;
    end
    // Watchdog advances on each rise of the timer's top bit.
    if (!st_reg.tmr[TMR_WD_BIT] && st_next.tmr[TMR_WD_BIT]) begin
      st_next.wdt = st_reg.wdt + 2'h1;
      st_next.watchdog_reset = !st_reg.wdt[1] && st_next.wdt[1];
    end
    // Port reads; unmapped and write-only addresses read as zero.
    // The low timer byte latches the high nibble, so a low-then-high pair
    // gives one consistent value even when a carry falls between them.
    if (IO_RD_IN) begin
      st_next.rdata = RST_VAL;
      unique case (IO_ADDR_IN)
        A_PORT_DATA: st_next.rdata = st_reg.pdata[0];
        A_PORT_DATA + 8'h01: st_next.rdata = st_reg.pdata[1];
        A_PORT_DATA + 8'h02: st_next.rdata = st_reg.pdata[2];
        A_PORT_DATA + 8'h03: st_next.rdata = st_reg.pdata[3];
        A_DRIVE_CFG: st_next.rdata = st_reg.dcfg;
        A_USB_ADDR: st_next.rdata = st_reg.uaddr;
        A_EP0_CNT: st_next.rdata = st_reg.ep0_cnt;
        A_EP0_MODE: st_next.rdata = st_reg.ep0_mode;
        A_EP1_CNT: st_next.rdata = st_reg.ep1_cnt;
        A_EP1_MODE: st_next.rdata = st_reg.ep1_mode;
        A_EP2_CNT: st_next.rdata = st_reg.ep2_cnt;
        A_EP2_MODE: st_next.rdata = st_reg.ep2_mode;
        A_TRAFFIC: st_next.rdata = st_reg.uctl;
        A_GLOBAL_IE: st_next.rdata = st_reg.gien;
        A_EP_IE: st_next.rdata = st_reg.eien;
        A_TMR_LO: begin
          st_next.rdata = st_reg.tmr[7:0];
          st_next.thi = st_reg.tmr[11:8];
        end
        A_TMR_HI: st_next.rdata = {4'h0, st_reg.thi};
        A_SINK_DATA: st_next.rdata = st_reg.sdata;
        A_CPU_STAT: st_next.rdata = st_reg.cstat;
        default: st_next.rdata = RST_VAL;
      endcase
    end
    // Port writes; addresses without a register are ignored.
    if (wr_any) begin
      unique case (wr_addr)
        A_PORT_DATA: st_next.pdata[0] = IO_ACC_IN;
        A_PORT_DATA + 8'h01: st_next.pdata[1] = IO_ACC_IN;
        A_PORT_DATA + 8'h02: st_next.pdata[2] = IO_ACC_IN;
        A_PORT_DATA + 8'h03: st_next.pdata[3] = IO_ACC_IN;
        A_PORT_IRQ_EN: st_next.pien[0] = IO_ACC_IN;
        A_PORT_IRQ_EN + 8'h01: st_next.pien[1] = IO_ACC_IN;
        A_PORT_IRQ_EN + 8'h02: st_next.pien[2] = IO_ACC_IN;
        A_PORT_IRQ_EN + 8'h03: st_next.pien[3] = IO_ACC_IN;
        A_DRIVE_CFG: st_next.dcfg = IO_ACC_IN;
        A_USB_ADDR: st_next.uaddr = IO_ACC_IN;
        A_EP0_CNT: st_next.ep0_cnt = IO_ACC_IN;
        A_EP0_MODE: st_next.ep0_mode = IO_ACC_IN;
        A_EP1_CNT: st_next.ep1_cnt = IO_ACC_IN;
        A_EP1_MODE: st_next.ep1_mode = st_reg.ep1_mode & IO_ACC_IN;
        A_EP2_CNT: st_next.ep2_cnt = IO_ACC_IN;
        A_EP2_MODE: st_next.ep2_mode = st_reg.ep2_mode & IO_ACC_IN;
        A_TRAFFIC: st_next.uctl = IO_ACC_IN;
        A_GLOBAL_IE: st_next.gien = IO_ACC_IN;
        A_EP_IE: st_next.eien = IO_ACC_IN;
        A_WD_RESTART: begin
          st_next.wdt = 2'h0;
          // A request raised in this same cycle still stands.
        end
        A_SINK_DATA: st_next.sdata = IO_ACC_IN;
        A_SINK_IE: st_next.sien = IO_ACC_IN;
        A_SINK_POL: st_next.spol = IO_ACC_IN;
        A_CPU_STAT: st_next.cstat = IO_ACC_IN;
        default: begin
        end
      endcase
      // Sink current settings occupy eight consecutive addresses.
      for (int i = 0; i < 8; i++) begin
        if (wr_addr == A_SINK_CUR + 8'(i)) begin
          st_next.scur[i] = IO_ACC_IN[3:0];
        end
      end
    end
    // Hardware set events win over a clearing write in the same cycle.
    // Applying them last means no write path above can undo an event.
    st_next.ep1_mode = st_next.ep1_mode | EP1_MODE_SET_IN;
    st_next.ep2_mode = st_next.ep2_mode | EP2_MODE_SET_IN;
    st_next.cstat[BIT_POR] = st_next.cstat[BIT_POR] | POR_EVENT_IN;
    st_next.cstat[BIT_USB_RST] = st_next.cstat[BIT_USB_RST] | USB_RST_EVENT_IN;
    st_next.cstat[BIT_WDR] = st_next.cstat[BIT_WDR] | WDR_EVENT_IN;
  end

  // Reset zeroes the whole state: PC at zero with nothing pushed, stack
  // pointers at zero, USB address cleared and every enable off.
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      st_reg <= '0;
    end else if (CLK_EN_IN) begin
      st_reg <= st_next;
    end
  end

  // The data RAM holds stacks, variables and FIFOs in one array.
  iosmm_data_ram u_ram (
    .clk_in(REF_CLK_IN),
    .srst_in(SRST_IN),
    .ce_in(CLK_EN_IN),
    .addr_in(ram_addr),
    .we_in(ram_we),
    .re_in(ram_re),
    .wdata_in(ram_wdata),
    .rdata_out(MEM_RDATA_OUT)
  );
  // Every RAM write, stack pushes included, takes MEM_WDATA_IN as its data.
  // The CPU routes the accumulator there itself, which spares a second data
  // path here; only DS_LOAD_IN and the port writes sample the accumulator port directly.

  // Every output is a register field.
  assign IO_RDATA_OUT = st_reg.rdata;
  assign PC_OUT = st_reg.pc;
  assign PC_RANGE_ERR_OUT = st_reg.pc_err;
  assign CALL_SP_OUT = st_reg.csp;
  assign DATA_SP_OUT = st_reg.dsp;
  assign FIFO_HIT_OUT = st_reg.fifo;
  assign PORT_DATA_OUT = st_reg.pdata;
  assign PORT_IRQ_EN_OUT = st_reg.pien;
  assign DRIVE_CFG_OUT = st_reg.dcfg;
  assign USB_ADDR_OUT = st_reg.uaddr;
  assign TRAFFIC_CTRL_OUT = st_reg.uctl;
  assign GLOBAL_IRQ_EN_OUT = st_reg.gien;
  assign EP_IRQ_EN_OUT = st_reg.eien;
  assign SINK_DATA_OUT = st_reg.sdata;
  assign SINK_IRQ_EN_OUT = st_reg.sien;
  assign SINK_POL_OUT = st_reg.spol;
  assign SINK_CUR_OUT = st_reg.scur;
  assign WDR_REQ_OUT = st_reg.watchdog_reset;
endmodule // iosmm_io_map

// file: src/iosmm_pkg.sv
// Purpose: Shared constants for the I/O space, memory map and reset block.
// Assumes: 100 MHz core clock, which stands for the doubled reference clock.
// Notes: All registers reset to zero.
package iosmm_pkg;
  // Program memory vector table.
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_BUS_RESET = 14'h0002;
  localparam logic [13:0] VEC_TMR_128US = 14'h0004;
  localparam logic [13:0] VEC_TMR_1MS = 14'h0006;
  localparam logic [13:0] VEC_EP0 = 14'h0008;
  localparam logic [13:0] VEC_EP1 = 14'h000a;
  localparam logic [13:0] VEC_EP2 = 14'h000c;
  localparam logic [13:0] VEC_SINK = 14'h0014;
  localparam logic [13:0] VEC_GPIO = 14'h0016;
  localparam logic [13:0] PROG_CODE_START = 14'h001a;
  localparam logic [13:0] PROG_STORE_END = 14'h1fdf;
  // Data memory layout.
  localparam int RAM_DEPTH = 256;
  localparam logic [7:0] CALL_STACK_BASE = 8'h00;
  localparam logic [7:0] EP2_FIFO_BASE = 8'he8;
  localparam logic [7:0] EP1_FIFO_BASE = 8'hf0;
  localparam logic [7:0] EP0_FIFO_BASE = 8'hf8;
  // I/O register addresses.
  localparam logic [7:0] A_PORT_DATA = 8'h00;
  localparam logic [7:0] A_PORT_IRQ_EN = 8'h04;
  localparam logic [7:0] A_DRIVE_CFG = 8'h08;
  localparam logic [7:0] A_USB_ADDR = 8'h10;
  localparam logic [7:0] A_EP0_CNT = 8'h11;
  localparam logic [7:0] A_EP0_MODE = 8'h12;
  localparam logic [7:0] A_EP1_CNT = 8'h13;
  localparam logic [7:0] A_EP1_MODE = 8'h14;
  localparam logic [7:0] A_EP2_CNT = 8'h15;
  localparam logic [7:0] A_EP2_MODE = 8'h16;
  localparam logic [7:0] A_TRAFFIC = 8'h1f;
  localparam logic [7:0] A_GLOBAL_IE = 8'h20;
  localparam logic [7:0] A_EP_IE = 8'h21;
  localparam logic [7:0] A_TMR_LO = 8'h24;
  localparam logic [7:0] A_TMR_HI = 8'h25;
  localparam logic [7:0] A_WD_RESTART = 8'h26;
  localparam logic [7:0] A_SINK_DATA = 8'h30;
  localparam logic [7:0] A_SINK_IE = 8'h31;
  localparam logic [7:0] A_SINK_POL = 8'h32;
  localparam logic [7:0] A_SINK_CUR = 8'h38;
  localparam logic [7:0] A_CPU_STAT = 8'hff;
  // Reset cause flags in the status register.
  localparam int BIT_POR = 4;
  localparam int BIT_USB_RST = 5;
  localparam int BIT_WDR = 6;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Timer tick derived from the clock rate.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
  localparam int TMR_WD_BIT = 11;
  // Interrupt source codes.
  typedef enum logic [2:0] {
    SRC_BUS_RESET, SRC_TMR_128US, SRC_TMR_1MS, SRC_EP0,
    SRC_EP1, SRC_EP2, SRC_SINK, SRC_GPIO
  } iosmm_irq_src_t;
endpackage

// file: src/iosmm_data_ram.sv
// Purpose: 256-byte data RAM shared by stacks, variables and endpoint FIFOs.
// Assumes: One access per cycle, chosen by the caller.
// Notes: Read data is registered and holds until the next read.
module iosmm_data_ram
  import iosmm_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic we_in,
  input wire logic re_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [RAM_DEPTH];
  logic [7:0] rdata_reg;

  // The array itself has no reset, as a real RAM would not.
  always_ff @(posedge clk_in) begin
    if (ce_in && we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  // Read register is cleared on reset so the output is defined.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_reg <= RST_VAL;
    end else if (ce_in && re_in) begin
      rdata_reg <= mem[addr_in];
    end
  end

  assign rdata_out = rdata_reg;
endmodule // iosmm_data_ram

// file: tb/iosmm_io_map_properties.sv
// Purpose: Port-level timing checks for the I/O map block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Reset checks carry no disable, so they see the reset cycles.
module iosmm_properties
  import iosmm_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  input wire logic CLK_EN_IN,
  input wire logic [7:0] IO_ADDR_IN,
  input wire logic [7:0] IO_X_IN,
  input wire logic [7:0] IO_ACC_IN,
  input wire logic IO_RD_IN,
  input wire logic IO_WR_IN,
  input wire logic IO_WRX_IN,
  input wire logic [7:0] IO_RDATA_OUT,
  input wire logic IRQ_TAKE_IN,
  input wire logic [2:0] IRQ_SRC_IN,
  input wire logic [13:0] PC_OUT,
  input wire logic PC_RANGE_ERR_OUT,
  input wire logic DS_PUSH_IN,
  input wire logic DS_POP_IN,
  input wire logic DS_LOAD_IN,
  input wire logic CS_PUSH_IN,
  input wire logic [7:0] CALL_SP_OUT,
  input wire logic [7:0] DATA_SP_OUT,
  input wire logic [7:0] USB_ADDR_OUT,
  input wire logic [7:0] GLOBAL_IRQ_EN_OUT,
  input wire logic [7:0] EP_IRQ_EN_OUT
);
  localparam logic [13:0] VTAB [0:7] = '{VEC_BUS_RESET, VEC_TMR_128US, VEC_TMR_1MS,
    VEC_EP0, VEC_EP1, VEC_EP2, VEC_SINK, VEC_GPIO};
  // Addresses that must read as zero: write-only places and the unassigned ones from 0x40 to 0xfe.
  wire logic wo_a = IO_ADDR_IN inside {[8'h04:8'h07], 8'h26, 8'h31, 8'h32,
    [8'h38:8'h3f], [8'h40:8'hfe]};
  default clocking cb @(posedge REF_CLK_IN); endclocking
  // The latch is only useful if the high read follows closely.
  sequence s_lo_rd;
    CLK_EN_IN && IO_RD_IN && IO_ADDR_IN == A_TMR_LO;
  endsequence
  sequence s_hi_rd;
    CLK_EN_IN && IO_RD_IN && IO_ADDR_IN == A_TMR_HI;
  endsequence
  a_reset_ptrs: assert property (SRST_IN |=> PC_OUT == 14'h0000 &&
    CALL_SP_OUT == 8'h00 && DATA_SP_OUT == 8'h00)
    else $error("pointers not cleared by reset");
  a_reset_irq: assert property (SRST_IN |=> USB_ADDR_OUT == 8'h00 &&
    GLOBAL_IRQ_EN_OUT == 8'h00 && EP_IRQ_EN_OUT == 8'h00)
    else $error("address or enables not cleared by reset");
  a_irq_vec: assert property (disable iff (SRST_IN)
    CLK_EN_IN && IRQ_TAKE_IN |=> PC_OUT == VTAB[$past(IRQ_SRC_IN)])
    else $error("wrong interrupt vector");
  a_range_err: assert property (disable iff (SRST_IN)
    PC_RANGE_ERR_OUT == (PC_OUT > PROG_STORE_END))
    else $error("range flag disagrees with program counter");
  a_port_wr: assert property (disable iff (SRST_IN)
    CLK_EN_IN && IO_WR_IN && IO_ADDR_IN == A_USB_ADDR |=> USB_ADDR_OUT == $past(IO_ACC_IN))
    else $error("port write lost");
  a_index_wr: assert property (disable iff (SRST_IN)
    CLK_EN_IN && IO_WRX_IN && 8'(IO_ADDR_IN + IO_X_IN) == A_USB_ADDR
    |=> USB_ADDR_OUT == $past(IO_ACC_IN))
    else $error("indexed write lost");
  a_wo_zero: assert property (disable iff (SRST_IN)
    CLK_EN_IN && IO_RD_IN && wo_a |=> IO_RDATA_OUT == 8'h00)
    else $error("write-only or unassigned read not zero");
  a_timer_pair: assert property (disable iff (SRST_IN)
    s_lo_rd ##[1:3] s_hi_rd |=> IO_RDATA_OUT[7:4] == 4'h0)
    else $error("timer high read wider than four bits");
  a_push_dec: assert property (disable iff (SRST_IN)
    CLK_EN_IN && DS_PUSH_IN |=> DATA_SP_OUT == $past(DATA_SP_OUT) - 8'h01)
    else $error("push did not step pointer down");
  a_pop_inc: assert property (disable iff (SRST_IN)
    CLK_EN_IN && DS_POP_IN && !DS_PUSH_IN |=> DATA_SP_OUT == $past(DATA_SP_OUT) + 8'h01)
    else $error("pop did not step pointer up");
  a_call_up: assert property (disable iff (SRST_IN)
    CLK_EN_IN && CS_PUSH_IN && !(DS_PUSH_IN || DS_POP_IN || DS_LOAD_IN)
    |=> CALL_SP_OUT == $past(CALL_SP_OUT) + 8'h01)
    else $error("call stack did not grow upward");
endmodule // iosmm_properties

bind iosmm_io_map iosmm_properties u_props (.REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN),
  .CLK_EN_IN(CLK_EN_IN), .IO_ADDR_IN(IO_ADDR_IN), .IO_X_IN(IO_X_IN), .IO_ACC_IN(IO_ACC_IN),
  .IO_RD_IN(IO_RD_IN), .IO_WR_IN(IO_WR_IN), .IO_WRX_IN(IO_WRX_IN),
  .IO_RDATA_OUT(IO_RDATA_OUT), .IRQ_TAKE_IN(IRQ_TAKE_IN), .IRQ_SRC_IN(IRQ_SRC_IN),
  .PC_OUT(PC_OUT), .PC_RANGE_ERR_OUT(PC_RANGE_ERR_OUT), .DS_PUSH_IN(DS_PUSH_IN),
  .DS_POP_IN(DS_POP_IN), .DS_LOAD_IN(DS_LOAD_IN), .CS_PUSH_IN(CS_PUSH_IN),
  .CALL_SP_OUT(CALL_SP_OUT), .DATA_SP_OUT(DATA_SP_OUT), .USB_ADDR_OUT(USB_ADDR_OUT),
  .GLOBAL_IRQ_EN_OUT(GLOBAL_IRQ_EN_OUT), .EP_IRQ_EN_OUT(EP_IRQ_EN_OUT));

// file: tb/iosmm_cpu_model.sv
// Purpose: CPU side of the port instructions, issued through one task.
// Assumes: Strobes rise after an edge and drop after the taking edge.
// Notes: The accumulator holds its value; address lines are scrambled when idle.
module iosmm_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] x_out,
  output logic [7:0] acc_out,
  output logic rd_out,
  output logic wr_out,
  output logic wrx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle state at time zero.
  initial begin
    {addr_out, x_out, acc_out, rd_out, wr_out, wrx_out} = '0;
  end
  // Kind 0 reads, 1 writes, 2 writes indexed; read data is taken one cycle on.
  task automatic op(input int k, input logic [7:0] a, input logic [7:0] x,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    addr_out <= a;
    x_out <= x;
    acc_out <= d;
    rd_out <= (k == 0);
    wr_out <= (k == 1);
    wrx_out <= (k == 2);
    @(posedge clk_in);
    {rd_out, wr_out, wrx_out} <= 3'h0;
    // Stale addresses would hide a decoder that ignores the strobes.
    addr_out <= ~a;
    x_out <= ~x;
    #1;
    q = rdata_in;
  endtask
endmodule // iosmm_cpu_model

// file: tb/test_io_space_memory_map.sv
// Purpose: Directed tests of the I/O map, vectors and stack pointers.
// Assumes: Timer steps every 100 cycles of the 100 MHz clock.
// Notes: The watchdog overflow is too slow to reach in this run.
module test_io_space_memory_map
  import iosmm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  // Pulse bits: 0 step, 1 load, 2 irq, 3 push, 4 pop, 5 dsp load, 6 call push,
  // 7 call pop, 8 mem write, 9 mem read, 10..12 reset cause events.
  logic [12:0] ctl = '0;
  logic [15:0] mset = '0;
  logic [13:0] ldval = '0;
  logic [2:0] src = '0;
  logic [7:0] madr = '0, wdat = '0, q, v1;
  logic [7:0] ia, ix, iacc, rdat, mdat, csp, dsp, usb, gie, eie, sie, spol, dcf, tfc, sdo;
  logic [13:0] pc;
  logic [31:0] pie, cur, pdo;
  logic [2:0] hit;
  logic ird, iwr, iwrx, rng, wdq;
  logic ce = 1'b1;
  int errors = 0, total_checks = 0, cyc = 0;
  localparam logic [7:0] RW [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h15, 8'h1f, 8'h20, 8'h21, 8'h30, 8'hff};
  localparam logic [7:0] WO [16] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h26, 8'h31, 8'h32,
    8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40};
  localparam logic [13:0] VT [8] = '{14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h000a,
    14'h000c, 14'h0014, 14'h0016};
  localparam logic [7:0] FA [3] = '{8'he8, 8'hf0, 8'hf8};
  // The core clock stands for the doubled reference.
  initial begin
    forever #5 clk = ~clk;
  end
  iosmm_cpu_model cpu (.clk_in(clk), .rdata_in(rdat), .addr_out(ia), .x_out(ix),
    .acc_out(iacc), .rd_out(ird), .wr_out(iwr), .wrx_out(iwrx));
  iosmm_io_map dut (.REF_CLK_IN(clk), .SRST_IN(srst), .CLK_EN_IN(ce), .IO_ADDR_IN(ia),
    .IO_X_IN(ix), .IO_ACC_IN(iacc), .IO_RD_IN(ird), .IO_WR_IN(iwr), .IO_WRX_IN(iwrx),
    .IO_RDATA_OUT(rdat), .PC_STEP_IN(ctl[0]), .PC_LOAD_IN(ctl[1]), .PC_LOAD_VAL_IN(ldval),
    .IRQ_TAKE_IN(ctl[2]), .IRQ_SRC_IN(src), .PC_OUT(pc), .PC_RANGE_ERR_OUT(rng),
    .DS_PUSH_IN(ctl[3]), .DS_POP_IN(ctl[4]), .DS_LOAD_IN(ctl[5]), .CS_PUSH_IN(ctl[6]),
    .CS_POP_IN(ctl[7]), .MEM_WR_IN(ctl[8]), .MEM_RD_IN(ctl[9]), .MEM_ADDR_IN(madr),
    .MEM_WDATA_IN(wdat), .MEM_RDATA_OUT(mdat), .CALL_SP_OUT(csp), .DATA_SP_OUT(dsp),
    .FIFO_HIT_OUT(hit), .EP1_MODE_SET_IN(mset[7:0]), .EP2_MODE_SET_IN(mset[15:8]),
    .POR_EVENT_IN(ctl[10]), .USB_RST_EVENT_IN(ctl[11]), .WDR_EVENT_IN(ctl[12]),
    .PORT_DATA_OUT(pdo), .PORT_IRQ_EN_OUT(pie), .DRIVE_CFG_OUT(dcf), .USB_ADDR_OUT(usb),
    .TRAFFIC_CTRL_OUT(tfc), .GLOBAL_IRQ_EN_OUT(gie), .EP_IRQ_EN_OUT(eie), .SINK_DATA_OUT(sdo),
    .SINK_IRQ_EN_OUT(sie), .SINK_POL_OUT(spol), .SINK_CUR_OUT(cur), .WDR_REQ_OUT(wdq));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // One-cycle pulse; outputs are settled when it returns.
  task automatic pulse(input int b);
    @(posedge clk) ctl[b] <= 1'b1;
    @(posedge clk) ctl[b] <= 1'b0;
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end
  // Main sequence of tests.
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check("pc", pc, 14'h0000);
    check("sp", {csp, dsp}, 16'h0000);
    check("irq", {usb, gie, eie}, 24'h0);
    $display("test reset done");
    foreach (RW[i]) begin
      cpu.op(1, RW[i], 8'h00, 8'(8'h5a + i), q);
      cpu.op(0, RW[i], 8'h00, 8'h00, q);
      check("rw", q, 8'(8'h5a + i));
    end
    foreach (WO[i]) begin
      cpu.op(1, WO[i], 8'h00, 8'(8'h30 + i), q);
      cpu.op(0, WO[i], 8'h00, 8'h00, q);
      check("wo", q, 8'h00);
    end
    check("pie", pie, 32'h33323130);
    check("cur", cur, 32'hedcba987);
    check("sink", {sie, spol}, 16'h3536);
    check("usb", usb, 8'h5f);
    check("pdo", pdo, 32'h5d5c5b5a);
    check("regs", {dcf, tfc, sdo}, 24'h5e6467);
    check("wdq", wdq, 1'b0);
    $display("test map done");
    cpu.op(2, 8'h00, 8'h10, 8'h33, q);
    check("wrx0", usb, 8'h33);
    cpu.op(2, 8'hf8, 8'h18, 8'h44, q);
    check("wrxw", usb, 8'h44);
    cpu.op(2, 8'h30, 8'h08, 8'h05, q);
    check("wrxc", cur[3:0], 4'h5);
    @(posedge clk) mset <= 16'hf0f0;
    @(posedge clk) mset <= 16'h0000;
    for (int e = 0; e < 2; e++) begin
      cpu.op(1, 8'(8'h14 + 2 * e), 8'h00, 8'h3c, q);
      cpu.op(1, 8'(8'h14 + 2 * e), 8'h00, 8'hff, q);
      cpu.op(0, 8'(8'h14 + 2 * e), 8'h00, 8'h00, q);
      check("mode", q, 8'h30);
    end
    $display("test index done");
    cpu.op(0, A_TMR_LO, 8'h00, 8'h00, v1);
    repeat (998) @(posedge clk);
    cpu.op(0, A_TMR_LO, 8'h00, 8'h00, q);
    check("tick", 8'(q - v1), 8'h0a);
    cpu.op(0, A_TMR_HI, 8'h00, 8'h00, q);
    check("thi", q, 8'h00);
    $display("test timer done");
    for (int s = 0; s < 8; s++) begin
      @(posedge clk) src <= 3'(s);
      pulse(2);
      check("vec", pc, VT[s]);
    end
    @(posedge clk) ldval <= 14'h1fdf;
    pulse(1);
    check("end", {pc, rng}, {14'h1fdf, 1'b0});
    pulse(0);
    check("over", {pc, rng}, {14'h1fe0, 1'b1});
    @(posedge clk) ce <= 1'b0;
    pulse(0);
    check("hold", {pc, rng}, {14'h1fe0, 1'b1});
    @(posedge clk) ce <= 1'b1;
    $display("test vectors done");
    cpu.op(1, 8'h40, 8'h00, 8'he8, q);
    pulse(5);
    check("dsl", dsp, 8'he8);
    @(posedge clk) wdat <= 8'h77;
    pulse(3);
    check("push", dsp, 8'he7);
    pulse(4);
    check("pop", {dsp, mdat}, 16'he877);
    @(posedge clk) wdat <= 8'h99;
    pulse(6);
    check("cpush", csp, 8'h01);
    @(posedge clk) madr <= 8'h00;
    pulse(9);
    check("cmem", mdat, 8'h99);
    pulse(7);
    check("cpop", {csp, mdat}, 16'h0099);
    foreach (FA[i]) begin
      @(posedge clk) madr <= FA[i];
      pulse(9);
      check("fifo", hit, 3'(3'b100 >> i));
    end
    cpu.op(1, 8'h40, 8'h00, 8'h00, q);
    pulse(5);
    @(posedge clk) wdat <= 8'h55;
    pulse(3);
    check("wrap", {dsp, hit}, {8'hff, 3'b001});
    @(posedge clk) madr <= 8'hff;
    pulse(9);
    check("top", mdat, 8'h55);
    $display("test stack done");
    cpu.op(1, A_CPU_STAT, 8'h00, 8'h00, q);
    for (int b = 0; b < 3; b++) begin
      pulse(10 + b);
      cpu.op(0, A_CPU_STAT, 8'h00, 8'h00, q);
      check("cause", q, 8'((8'h10 << (b + 1)) - 8'h10));
    end
    @(posedge clk) srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    cpu.op(0, A_CPU_STAT, 8'h00, 8'h00, q);
    check("rst2", {q, usb, csp, dsp}, 32'h0);
    check("rst2pc", pc, 14'h0);
    $display("test status done");
    stop_test();
  end
endmodule // test_io_space_memory_map
